// file: rtl/tcsr_regs.sv
// Summary of operation
// R01: Attach state is a read-only 2-bit field; reset shows not attached.
// R02: Cable orientation bit reads 0 for CC1, 1 for CC2; resets to 1.
// R03: Any status change pulls the interrupt pin low and sets interrupt status.
// R04: Interrupt status stays 1 until the host clears it.
// R05: Over-current trip sets a clear-on-read fault bit, reset 0.
// R06: A set fault bit holds the interrupt pin low.
// R07: Source share of toggle period: 30, 40, 50 or 60 percent.
// R08: Sink accessory support bit: 0 enabled, 1 disabled.
// R09: Debounce select: 168, 118, 134 or 152 ms.
// R10: Port role select: DRP, UFP or DFP; 00 and 11 both DRP.
// R11: Role select applies only when the address strap selects serial mode.
// R12: Writing 1 to soft reset starts it; bit self-clears when done.
// R13: Soft reset may change attach, orientation and other detected status.
// R14: Dual-role preference: standard, Try.SNK, reserved, Try.SRC.
// R15: Termination-disable bit removes terminations and holds the CC logic off; here it is only stored in ctrl_r, ccLogicReset_r ignores it.
// R16: Interrupt pin releases once interrupt status and fault are both clear.
`timescale 1ns/100ps
module tcsr_regs #(
  parameter int DEB0_CYC = tcsr_pkg::DEB0_MS * tcsr_pkg::CYC_PER_MS,
  parameter int DEB1_CYC = tcsr_pkg::DEB1_MS * tcsr_pkg::CYC_PER_MS,
  parameter int DEB2_CYC = tcsr_pkg::DEB2_MS * tcsr_pkg::CYC_PER_MS,
  parameter int DEB3_CYC = tcsr_pkg::DEB3_MS * tcsr_pkg::CYC_PER_MS,
  parameter int SRST_CYC = tcsr_pkg::SRST_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire tcsr_pkg::tcsr_status_t statusIn,
  input  wire logic                   cablePowerOvercurrent,
  input  wire logic                   addrStrapSerial,
  output logic [7:0]                  regRdata_r,
  output logic                        intPinOut_r,
  output logic                        intPinOe_r,
  output tcsr_pkg::tcsr_ctrl_t        ctrl_r,
  output tcsr_pkg::tcsr_status_t      status_r,
  output tcsr_pkg::tcsr_role_t        effectiveRole_r,
  output logic [23:0]                 debounceCycles_r,
  output logic                        ccLogicReset_r
);

  if (DEB0_CYC < 1 || DEB0_CYC >= (1 << tcsr_pkg::DEB_CNT_W) ||
      DEB1_CYC < 1 || DEB1_CYC >= (1 << tcsr_pkg::DEB_CNT_W) ||
      DEB2_CYC < 1 || DEB2_CYC >= (1 << tcsr_pkg::DEB_CNT_W) ||
      DEB3_CYC < 1 || DEB3_CYC >= (1 << tcsr_pkg::DEB_CNT_W)) begin : g_bad_deb
    $error("debounce count out of range");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offset);
    addrHit = (addr == offset);
  endfunction : addrHit

  logic hitCsc;
  logic hitGc;
  logic wrCsc;
  logic wrGc;
  logic rdCsc;

  assign hitCsc = addrHit(regAddr, tcsr_pkg::CSC_OFFSET);
  assign hitGc  = addrHit(regAddr, tcsr_pkg::GC_OFFSET);
  assign wrCsc  = regWrite & hitCsc;
  assign wrGc   = regWrite & hitGc;
  assign rdCsc  = regRead & hitCsc;

  // ---------------------------------------------------------------
  // Soft reset and interrupt helpers
  // ---------------------------------------------------------------
  logic srstStart;
  logic srstBusy;
  logic intClear;
  logic intStatus;
  logic faultBit;
  logic intOe;
  logic statusChange;
  logic changeEvt;

  assign srstStart = wrGc & regWdata[tcsr_pkg::GC_SRST_BIT]; // R12
  assign intClear  = wrCsc & regWdata[tcsr_pkg::CSC_INT_BIT]; // R04

  tcsr_srst_seq #(
    .CYCLES (SRST_CYC)
  ) u_srst (
    .clock     (clock),
    .rst       (rst),
    .start     (srstStart),
    .busy_r    (srstBusy),
    .ccReset_r (ccLogicReset_r)
  );

  tcsr_int_ctrl u_int (
    .clock       (clock),
    .rst         (rst),
    .changeEvt   (changeEvt),
    .intClear    (intClear),
    .faultEvt    (cablePowerOvercurrent),
    .faultRead   (rdCsc),
    .intStatus_r (intStatus),
    .fault_r     (faultBit),
    .intOe_r     (intOe)
  );

  // ---------------------------------------------------------------
  // Status capture
  // ---------------------------------------------------------------
  tcsr_pkg::tcsr_status_t status_nxt;

  // Soft reset forces detected status back to its reset view
  assign status_nxt   = srstBusy ? tcsr_pkg::STATUS_RESET : statusIn; // R13
  assign statusChange = (status_nxt != status_r);
  // A new fault also counts as a status change
  assign changeEvt    = statusChange | (cablePowerOvercurrent & ~faultBit); // R03

  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= tcsr_pkg::STATUS_RESET; // R01 R02
    end else begin
      status_r <= status_nxt; // R01 R02
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  tcsr_pkg::tcsr_ctrl_t ctrlReset;
  tcsr_pkg::tcsr_ctrl_t ctrl_nxt;

  assign ctrlReset = '{
    debounce:            tcsr_pkg::GC_RESET[tcsr_pkg::GC_DEB_MSB:tcsr_pkg::GC_DEB_LSB],
    role:                tcsr_pkg::ROLE_DRP,
    dualRoleTryPref:     tcsr_pkg::PREF_STD,
    termDisable:         tcsr_pkg::GC_RESET[tcsr_pkg::GC_TERM_BIT],
    dualRoleSourceShare: tcsr_pkg::SHARE_30,
    sinkAccessoryOff:    tcsr_pkg::CSC_RESET[tcsr_pkg::CSC_ACC_BIT]
  };

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wrCsc) begin
      ctrl_nxt.dualRoleSourceShare =
        tcsr_pkg::tcsr_share_t'(regWdata[tcsr_pkg::CSC_DUTY_MSB:tcsr_pkg::CSC_DUTY_LSB]); // R07
      ctrl_nxt.sinkAccessoryOff = regWdata[tcsr_pkg::CSC_ACC_BIT]; // R08
    end
    if (wrGc) begin
      ctrl_nxt.debounce = regWdata[tcsr_pkg::GC_DEB_MSB:tcsr_pkg::GC_DEB_LSB]; // R09
      ctrl_nxt.role =
        tcsr_pkg::tcsr_role_t'(regWdata[tcsr_pkg::GC_ROLE_MSB:tcsr_pkg::GC_ROLE_LSB]); // R10
      ctrl_nxt.dualRoleTryPref =
        tcsr_pkg::tcsr_pref_t'(regWdata[tcsr_pkg::GC_PREF_MSB:tcsr_pkg::GC_PREF_LSB]); // R14
      ctrl_nxt.termDisable = regWdata[tcsr_pkg::GC_TERM_BIT]; // R15
    end
  end

  // ---------------------------------------------------------------
  // Derived controls
  // ---------------------------------------------------------------
  tcsr_pkg::tcsr_role_t roleSel;
  logic [23:0]          debSel;

  // Without the serial-mode strap the port stays dual role
  assign roleSel = addrStrapSerial ? ctrl_nxt.role : tcsr_pkg::ROLE_DRP; // R10 R11
  assign debSel  = (ctrl_nxt.debounce == 2'h0) ? 24'(DEB0_CYC) :
                   (ctrl_nxt.debounce == 2'h1) ? 24'(DEB1_CYC) :
                   (ctrl_nxt.debounce == 2'h2) ? 24'(DEB2_CYC) : 24'(DEB3_CYC); // R09

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] cscValue;
  logic [7:0] gcValue;
  logic [7:0] rd_nxt;

  assign cscValue = {status_r.attach, status_r.cableDir, intStatus, faultBit,
                     ctrl_r.dualRoleSourceShare, ctrl_r.sinkAccessoryOff}; // R01 R02
  // Soft reset bit reads 1 only while the reset runs
  assign gcValue  = {ctrl_r.debounce, ctrl_r.role, srstBusy,
                     ctrl_r.dualRoleTryPref, ctrl_r.termDisable}; // R12
  assign rd_nxt   = hitCsc ? cscValue :
                    hitGc  ? gcValue  : tcsr_pkg::RD_UNMAPPED;

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r           <= ctrlReset;
      effectiveRole_r  <= tcsr_pkg::ROLE_DRP;
      debounceCycles_r <= 24'(DEB0_CYC);
      regRdata_r       <= 8'h00;
      intPinOut_r      <= 1'b0;
      intPinOe_r       <= 1'b0;
    end else begin
      ctrl_r           <= ctrl_nxt;
      effectiveRole_r  <= roleSel;
      debounceCycles_r <= debSel;
      regRdata_r       <= regRead ? rd_nxt : regRdata_r;
      intPinOut_r      <= 1'b0;
      intPinOe_r       <= intOe; // R03 R06 R16
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_attach_track;
    !srstBusy |=> status_r.attach == $past(statusIn.attach);
  endproperty
  a_attach_track: assert property (p_attach_track) else $error("attach not tracked"); // R01

  property p_dir_reset;
    $fell(rst) |-> status_r.cableDir == 1'b1;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("orientation reset wrong"); // R02

  property p_change_pin;
    statusChange |=> ##1 !intPinOe_r == 1'b0;
  endproperty
  a_change_pin: assert property (p_change_pin) else $error("pin not driven after change"); // R03

  property p_fault_read;
    (rdCsc && faultBit && !cablePowerOvercurrent) |=> regRdata_r[3] && !faultBit;
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault not cleared on read"); // R05

  property p_share_write;
    wrCsc |=> ctrl_r.dualRoleSourceShare == $past(regWdata[2:1]);
  endproperty
  a_share_write: assert property (p_share_write) else $error("share field not written"); // R07

  property p_accessory_write;
    wrCsc |=> ctrl_r.sinkAccessoryOff == $past(regWdata[0]);
  endproperty
  a_accessory_write: assert property (p_accessory_write) else $error("accessory bit wrong"); // R08

  property p_debounce_map;
    (ctrl_r.debounce == 2'h1 && !wrGc) |=> debounceCycles_r == 24'(DEB1_CYC);
  endproperty
  a_debounce_map: assert property (p_debounce_map) else $error("debounce count wrong"); // R09

  property p_role_strap;
    (wrGc && regWdata[5:4] == 2'h2 && addrStrapSerial) |=>
      effectiveRole_r == tcsr_pkg::ROLE_DFP;
  endproperty
  a_role_strap: assert property (p_role_strap) else $error("role not applied"); // R10

  property p_role_no_strap;
    !addrStrapSerial |=> effectiveRole_r == tcsr_pkg::ROLE_DRP;
  endproperty
  a_role_no_strap: assert property (p_role_no_strap) else $error("role applied without strap"); // R11

  property p_srst_status;
    srstBusy |=> status_r == tcsr_pkg::STATUS_RESET;
  endproperty
  a_srst_status: assert property (p_srst_status) else $error("status kept in soft reset"); // R13

  property p_pref_write;
    wrGc |=> ctrl_r.dualRoleTryPref == $past(regWdata[2:1]);
  endproperty
  a_pref_write: assert property (p_pref_write) else $error("preference not written"); // R14

  property p_term_write;
    wrGc |=> ctrl_r.termDisable == $past(regWdata[0]);
  endproperty
  a_term_write: assert property (p_term_write) else $error("termination bit wrong"); // R15

  property p_dir_track;
    !srstBusy |=> status_r.cableDir == $past(statusIn.cableDir);
  endproperty
  a_dir_track: assert property (p_dir_track) else $error("orientation not tracked"); // R02

  property p_srst_start;
    (srstStart && !srstBusy) |=> srstBusy && ccLogicReset_r;
  endproperty
  a_srst_start: assert property (p_srst_start) else $error("soft reset not started"); // R12

  property p_fault_pin_top;
    faultBit |=> intPinOe_r;
  endproperty
  a_fault_pin_top: assert property (p_fault_pin_top) else $error("fault left pin free"); // R06

  property p_release_top;
    (!intStatus && !faultBit) |=> !intPinOe_r;
  endproperty
  a_release_top: assert property (p_release_top) else $error("pin held without cause"); // R16

  property p_gc_hold;
    !wrGc |=> $stable(ctrl_r[9:3]);
  endproperty
  a_gc_hold: assert property (p_gc_hold) else $error("general control drifted"); // R14

  property p_csc_hold;
    !wrCsc |=> $stable(ctrl_r[2:0]);
  endproperty
  a_csc_hold: assert property (p_csc_hold) else $error("share or accessory drifted"); // R07

  property p_role_ufp;
    (wrGc && regWdata[5:4] == 2'h1 && addrStrapSerial) |=>
      effectiveRole_r == tcsr_pkg::ROLE_UFP;
  endproperty
  a_role_ufp: assert property (p_role_ufp) else $error("sink role not applied"); // R10

  c_attach_src: cover property (status_r.attach == tcsr_pkg::ATT_SRC && intPinOe_r);
  c_fault_clear: cover property (faultBit ##1 rdCsc ##1 !faultBit);
  c_soft_reset: cover property (srstStart ##[1:8] !srstBusy);
  c_int_release: cover property (intPinOe_r ##1 intClear ##[1:3] !intPinOe_r);

endmodule : tcsr_regs

// file: rtl/tcsr_pkg.sv
package tcsr_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CSC_OFFSET = 8'h09;
  localparam logic [7:0] GC_OFFSET  = 8'h0a;
  localparam logic [7:0] CSC_RESET  = 8'h20;
  localparam logic [7:0] GC_RESET   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSC_ATT_MSB  = 7;
  localparam int CSC_ATT_LSB  = 6;
  localparam int CSC_DIR_BIT  = 5;
  localparam int CSC_INT_BIT  = 4;
  localparam int CSC_FLT_BIT  = 3;
  localparam int CSC_DUTY_MSB = 2;
  localparam int CSC_DUTY_LSB = 1;
  localparam int CSC_ACC_BIT  = 0;
  localparam int GC_DEB_MSB   = 7;
  localparam int GC_DEB_LSB   = 6;
  localparam int GC_ROLE_MSB  = 5;
  localparam int GC_ROLE_LSB  = 4;
  localparam int GC_SRST_BIT  = 3;
  localparam int GC_PREF_MSB  = 2;
  localparam int GC_PREF_LSB  = 1;
  localparam int GC_TERM_BIT  = 0;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ATT_NONE = 2'h0,
    ATT_SRC  = 2'h1,
    ATT_SNK  = 2'h2,
    ATT_ACC  = 2'h3
  } tcsr_attach_t;

  typedef enum logic [1:0] {
    ROLE_DRP     = 2'h0,
    ROLE_UFP     = 2'h1,
    ROLE_DFP     = 2'h2,
    ROLE_DRP_ALT = 2'h3
  } tcsr_role_t;

  typedef enum logic [1:0] {
    PREF_STD     = 2'h0,
    PREF_TRY_SNK = 2'h1,
    PREF_RSVD    = 2'h2,
    PREF_TRY_SRC = 2'h3
  } tcsr_pref_t;

  typedef enum logic [1:0] {
    SHARE_30 = 2'h0,
    SHARE_40 = 2'h1,
    SHARE_50 = 2'h2,
    SHARE_60 = 2'h3
  } tcsr_share_t;

  localparam logic        DIR_RESET = 1'b1;
  localparam tcsr_attach_t ATT_RESET = ATT_NONE;

  typedef struct packed {
    tcsr_attach_t attach;
    logic         cableDir;
  } tcsr_status_t;

  typedef struct packed {
    logic [1:0]  debounce;
    tcsr_role_t  role;
    tcsr_pref_t  dualRoleTryPref;
    logic        termDisable;
    tcsr_share_t dualRoleSourceShare;
    logic        sinkAccessoryOff;
  } tcsr_ctrl_t;

  localparam tcsr_status_t STATUS_RESET = '{attach: ATT_RESET, cableDir: DIR_RESET};

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 50000000;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int DEB0_MS      = 168;
  localparam int DEB1_MS      = 118;
  localparam int DEB2_MS      = 134;
  localparam int DEB3_MS      = 152;
  localparam int SRST_CYCLES  = 4;
  localparam int DEB_CNT_W    = 24;

endpackage : tcsr_pkg

// file: rtl/tcsr_srst_seq.sv
`timescale 1ns/100ps
module tcsr_srst_seq #(
  parameter int CYCLES = tcsr_pkg::SRST_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy_r,
  output logic      ccReset_r
);

  if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
    $error("CYCLES out of range");
  end

  typedef enum logic {
    SRST_IDLE = 1'b0,
    SRST_RUN  = 1'b1
  } tcsr_srst_state_t;

  tcsr_srst_state_t state_r;
  tcsr_srst_state_t state_nxt;
  logic [7:0]       count_r;
  logic [7:0]       count_nxt;
  logic             lastCycle;

  assign lastCycle = (count_r == 8'(CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      SRST_IDLE: begin
        count_nxt = 8'h00;
        if (start) begin
          state_nxt = SRST_RUN;
        end
      end
      SRST_RUN: begin
        count_nxt = count_r + 8'h01;
        if (lastCycle) begin
          state_nxt = SRST_IDLE;
        end
      end
      default: begin
        state_nxt = SRST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r   <= SRST_IDLE;
      count_r   <= 8'h00;
      busy_r    <= 1'b0;
      ccReset_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      count_r   <= count_nxt;
      busy_r    <= (state_nxt == SRST_RUN); // R12
      ccReset_r <= (state_nxt == SRST_RUN); // R13
    end
  end

  property p_srst_len;
    @(posedge clock) disable iff (rst)
    (start && !busy_r) |=> busy_r [*4] ##1 !busy_r;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong"); // R12

  property p_srst_reset_out;
    @(posedge clock) disable iff (rst)
    busy_r |-> ccReset_r;
  endproperty
  a_srst_reset_out: assert property (p_srst_reset_out) else $error("logic reset missing"); // R13

endmodule : tcsr_srst_seq

// file: rtl/tcsr_int_ctrl.sv
`timescale 1ns/100ps
module tcsr_int_ctrl (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic changeEvt,
  input  wire logic intClear,
  input  wire logic faultEvt,
  input  wire logic faultRead,
  output logic      intStatus_r,
  output logic      fault_r,
  output logic      intOe_r
);

  logic intStatus_nxt;
  logic fault_nxt;

  // Set wins over a clear in the same cycle
  assign intStatus_nxt = changeEvt | (intStatus_r & ~intClear); // R03 R04
  assign fault_nxt     = faultEvt | (fault_r & ~faultRead);     // R05

  always_ff @(posedge clock) begin
    if (rst) begin
      intStatus_r <= 1'b0;
      fault_r     <= 1'b0;
      intOe_r     <= 1'b0;
    end else begin
      intStatus_r <= intStatus_nxt;
      fault_r     <= fault_nxt;
      intOe_r     <= intStatus_nxt | fault_nxt; // R06 R16
    end
  end

  property p_int_set;
    @(posedge clock) disable iff (rst)
    changeEvt |=> intStatus_r && intOe_r;
  endproperty
  a_int_set: assert property (p_int_set) else $error("change did not raise interrupt"); // R03

  property p_int_hold;
    @(posedge clock) disable iff (rst)
    (intStatus_r && !intClear) |=> intStatus_r;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt status dropped"); // R04

  property p_fault_set;
    @(posedge clock) disable iff (rst)
    faultEvt |=> fault_r;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not captured"); // R05

  property p_fault_pin;
    @(posedge clock) disable iff (rst)
    fault_r |-> intOe_r;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault without pin low"); // R06

  property p_pin_release;
    @(posedge clock) disable iff (rst)
    (!intStatus_r && !fault_r) |-> !intOe_r;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released"); // R16

endmodule : tcsr_int_ctrl

// file: verification/tcsr_host_model.sv
`timescale 1ns/100ps
module tcsr_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] regRdata_r,
  input  wire logic       intPinOut_r,
  input  wire logic       intPinOe_r,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata,
  output logic            regWrite,
  output logic            regRead,
  output wire logic       intLine
);
  // External pull-up holds the open-drain line high while released
  assign intLine = intPinOe_r ? intPinOut_r : 1'b1;

  initial begin
    regAddr  = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end

  // ---------------------------------------------------------------
  // Register accesses
  // ---------------------------------------------------------------
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    regAddr  = addr;
    regWdata = data;
    regWrite = 1'b1;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    // Released bus no longer shows the last value
    regAddr  = ~addr;
    regWdata = ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock);
    #1;
    regAddr = addr;
    regRead = 1'b1;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    regAddr = ~addr;
    @(posedge clock);
    #1;
    data = regRdata_r;
  endtask : read_reg
endmodule : tcsr_host_model

// file: verification/tb_typec_cc_status_control_regs.sv
`timescale 1ns/100ps
module tb_typec_cc_status_control_regs;
  localparam logic [23:0] DEB_TAB [4] = '{24'h00000a, 24'h000014, 24'h00001e, 24'h000028};

  logic                   clock;
  logic                   rst;
  logic [7:0]             regAddr;
  logic [7:0]             regWdata;
  logic                   regWrite;
  logic                   regRead;
  tcsr_pkg::tcsr_status_t statusIn;
  logic                   cablePowerOvercurrent;
  logic                   addrStrapSerial;
  logic [7:0]             regRdata_r;
  logic                   intPinOut_r;
  logic                   intPinOe_r;
  tcsr_pkg::tcsr_ctrl_t   ctrl_r;
  tcsr_pkg::tcsr_status_t status_r;
  tcsr_pkg::tcsr_role_t   effectiveRole_r;
  logic [23:0]            debounceCycles_r;
  logic                   ccLogicReset_r;
  wire logic              intLine;
  logic [7:0]             rd;
  int                     fails;
  int                     compares;

  tcsr_regs #(
    .DEB0_CYC(10), .DEB1_CYC(20), .DEB2_CYC(30), .DEB3_CYC(40), .SRST_CYC(4)
  ) DUT (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .statusIn(statusIn),
    .cablePowerOvercurrent(cablePowerOvercurrent), .addrStrapSerial(addrStrapSerial),
    .regRdata_r(regRdata_r), .intPinOut_r(intPinOut_r), .intPinOe_r(intPinOe_r),
    .ctrl_r(ctrl_r), .status_r(status_r), .effectiveRole_r(effectiveRole_r),
    .debounceCycles_r(debounceCycles_r), .ccLogicReset_r(ccLogicReset_r)
  );

  tcsr_host_model hostModel (
    .clock(clock), .regRdata_r(regRdata_r), .intPinOut_r(intPinOut_r),
    .intPinOe_r(intPinOe_r), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .intLine(intLine)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
    hostModel.read_reg(addr, rd);
    chk(what, {16'h0000, exp}, {16'h0000, rd});
  endtask : rd_chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles

  task automatic do_reset();
    @(posedge clock);
    #1;
    rst = 1'b1;
    statusIn = tcsr_pkg::STATUS_RESET;
    cablePowerOvercurrent = 1'b0;
    addrStrapSerial = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
  endtask : do_reset

  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    do_reset();
    rd_chk(8'h09, 8'h20, "status control reset");
    rd_chk(8'h0a, 8'h00, "general control reset");
    chk("debounce count", DEB_TAB[0], debounceCycles_r);
    chk("int line idle", 24'h000001, {23'h000000, intLine});
    hostModel.write_reg(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'h00, "unmapped read");
    rd_chk(8'h0a, 8'h00, "general control after unmapped write");
  endtask : t_reset_values

  task automatic t_control_fields();
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      hostModel.write_reg(8'h0a, {v, v, 1'b0, v, v[0]});
      rd_chk(8'h0a, {v, v, 1'b0, v, v[0]}, "general control readback");
      chk("debounce count", DEB_TAB[i], debounceCycles_r);
      chk("effective role", {22'h000000, v}, {22'h000000, effectiveRole_r});
      chk("term disable", {23'h000000, v[0]}, {23'h000000, ctrl_r.termDisable});
      hostModel.write_reg(8'h09, {3'b111, 1'b0, 1'b1, v, v[0]});
      rd_chk(8'h09, {5'b00100, v, v[0]}, "status control readback");
      chk("source share", {22'h000000, v}, {22'h000000, ctrl_r.dualRoleSourceShare});
      chk("accessory off", {23'h000000, v[0]}, {23'h000000, ctrl_r.sinkAccessoryOff});
    end
  endtask : t_control_fields

  task automatic t_strap();
    do_reset();
    addrStrapSerial = 1'b0;
    hostModel.write_reg(8'h0a, 8'h20);
    cycles(3);
    chk("role without strap", {22'h000000, tcsr_pkg::ROLE_DRP}, {22'h000000, effectiveRole_r});
    addrStrapSerial = 1'b1;
    cycles(3);
    chk("role with strap", {22'h000000, tcsr_pkg::ROLE_DFP}, {22'h000000, effectiveRole_r});
  endtask : t_strap

  task automatic t_status_irq();
    logic [1:0] a;
    do_reset();
    for (int i = 1; i < 4; i++) begin
      a = 2'(i);
      statusIn = {a, ~a[0]};
      cycles(4);
      chk("int line on change", 24'h000000, {23'h000000, intLine});
      rd_chk(8'h09, {a, ~a[0], 5'h10}, "status after change");
      rd_chk(8'h09, {a, ~a[0], 5'h10}, "int status held");
      hostModel.write_reg(8'h09, 8'h10);
      cycles(3);
      chk("int line released", 24'h000001, {23'h000000, intLine});
      rd_chk(8'h09, {a, ~a[0], 5'h00}, "int status cleared");
    end
  endtask : t_status_irq

  task automatic t_fault();
    do_reset();
    cablePowerOvercurrent = 1'b1;
    cycles(1);
    cablePowerOvercurrent = 1'b0;
    cycles(3);
    chk("int line on fault", 24'h000000, {23'h000000, intLine});
    hostModel.write_reg(8'h09, 8'h10);
    cycles(4);
    chk("fault holds int line", 24'h000000, {23'h000000, intLine});
    rd_chk(8'h09, 8'h28, "fault bit set");
    rd_chk(8'h09, 8'h20, "fault cleared on read");
    cycles(3);
    chk("int line after fault read", 24'h000001, {23'h000000, intLine});
  endtask : t_fault

  task automatic t_soft_reset();
    do_reset();
    statusIn = 3'b010;
    cycles(4);
    hostModel.write_reg(8'h09, 8'h10);
    hostModel.write_reg(8'h0a, 8'h9a);
    chk("cc logic reset", 24'h000001, {23'h000000, ccLogicReset_r});
    cycles(1);
    chk("status during reset", {21'h000000, tcsr_pkg::STATUS_RESET}, {21'h000000, status_r});
    rd_chk(8'h0a, 8'h9a, "soft reset busy");
    cycles(8);
    chk("cc logic reset done", 24'h000000, {23'h000000, ccLogicReset_r});
    rd_chk(8'h0a, 8'h92, "soft reset self clear");
    rd_chk(8'h09, 8'h50, "status after soft reset");
  endtask : t_soft_reset

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    fails = 0;
    compares = 0;
    rst = 1'b1;
    statusIn = tcsr_pkg::STATUS_RESET;
    cablePowerOvercurrent = 1'b0;
    addrStrapSerial = 1'b1;
    t_reset_values();
    t_control_fields();
    t_strap();
    t_status_irq();
    t_fault();
    t_soft_reset();
    test_done();
  end

  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule : tb_typec_cc_status_control_regs
